// File: rtl/selftest_pkg.sv
/*
  Shared constants and types of the memory self-test background and bypass block.
  Assumes one 8-bit wide, 64-word memory with a column mux of four, clocked by sys_clk at 50 MHz.
*/
package selftest_pkg;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 6;
  localparam int COL_MUX     = 4;
  localparam int COL_BIT     = $clog2(COL_MUX);
  localparam int SHARE_N     = 4;
  localparam int BYP_REGS    = DATA_W / SHARE_N;

  // ****************************************
  // Background table and select codes
  // ****************************************
  localparam logic [DATA_W-1:0] PAT_SOLID  = 8'h00;
  localparam logic [DATA_W-1:0] PAT_CHECK  = 8'h55;
  localparam logic [1:0]        SEL_SOLID  = 2'h1;
  localparam logic [1:0]        SEL_CHECK  = 2'h2;
  localparam logic              CS_ON      = 1'b1;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_CLK_NS  = 20;
  localparam int SLEEP_NS    = 1000000;
  localparam int SLEEP_CYC   = SLEEP_NS / SYS_CLK_NS;

  typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_SLEEP, ST_READ, ST_DONE} seq_state_t;

endpackage

// File: rtl/bg_if.sv
/*
  Interface between the test sequencer and the background generator.
  Assumes both ends sit in the same sys_clk domain; all signals are combinational.
*/
`timescale 1ns/100ps
interface pattern_if;
  import selftest_pkg::*;
  logic [1:0]        pat_index;
  logic [ADDR_W-1:0] addr;
  logic              style_check;
  logic [1:0]        background_select;
  logic              custom_en;
  logic              custom_two;
  logic [DATA_W-1:0] custom_a;
  logic [DATA_W-1:0] custom_b;
  logic              addr_inv_en;
  logic              col_inv_en;
  logic [DATA_W-1:0] pattern;
  logic [2:0]        pat_count;

  modport gen  (input pat_index, addr, style_check, background_select, custom_en, custom_two,
                input custom_a, custom_b, addr_inv_en, col_inv_en,
                output pattern, pat_count);
  modport user (output pat_index, addr, style_check, background_select, custom_en, custom_two,
                output custom_a, custom_b, addr_inv_en, col_inv_en,
                input pattern, pat_count);
endinterface

// File: rtl/bg_gen.sv
/*
  Background generator: maps a background index and an address to the test word.
  Assumes the sequencer holds the index below the pattern count.
*/
`timescale 1ns/100ps
module pattern_gen
  import selftest_pkg::*;
(
  pattern_if.gen b
);

  // ****************************************
  // Background list and inversion
  // ****************************************
  logic [DATA_W-1:0] raw;
  logic              flip;

  always_comb
  begin
    raw         = PAT_SOLID;
    b.pat_count = 3'h1;
    if (b.custom_en && !b.style_check)
    begin
      raw = b.custom_a;
    end
    else if (b.custom_en)
    begin
      b.pat_count = 3'h4;
      unique case (b.pat_index)
        2'h0:    raw = b.custom_a;
        2'h1:    raw = ~b.custom_a;
        2'h2:    raw = b.custom_two ? b.custom_b : PAT_CHECK;
        default: raw = b.custom_two ? ~b.custom_b : ~PAT_CHECK;
      endcase
    end
    else if (b.style_check)
    begin
      if (b.background_select == SEL_SOLID)
        raw = PAT_SOLID;
      else if (b.background_select == SEL_CHECK)
        raw = PAT_CHECK;
      else
      begin
        b.pat_count = 3'h2;
        raw         = (b.pat_index == 2'h0) ? PAT_SOLID : PAT_CHECK;
      end
    end
  end

  // Both inversions fold together, so enabling both gives their XOR.
  assign flip      = (b.addr_inv_en & b.addr[0]) ^ (b.col_inv_en & b.addr[COL_BIT]);
  assign b.pattern = flip ? ~raw : raw;

endmodule

// File: rtl/mbist_background_and_bypass.sv
/*
  Memory self-test sequencer with background generation, retention sleep and bypass path.
  Assumes the memory registers read data one cycle after it samples a read, runs on sys_clk
  through an external gate driven by mem_clk_en, and that all inputs are synchronous.
*/
`timescale 1ns/100ps
// Function
// - Select field picks solid, checker or both.
// - Solid and checkerboard come from fixed table.
// - Odd addresses get complemented background.
// - Flip background every column-mux addresses.
// - Custom solid uses the custom value.
// - Custom checker adds complements, default pair.
// - Sleep pauses one millisecond plus extension.
// - Retention runs timed or by handshake.
// - Bypass folds memory inputs onto read data.
// - Bypass switches scan clock to test clock.
// - Disabled bypass: chip select off, clock low.
// - Enabled bypass: chip select on, clock runs.
// - Bypass registers shared by output bit groups.
// - Bypass registers step on bypass clock.
// - Loop mode restarts testing without idle.
module mbist_background_and_bypass
  import selftest_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_CYC,
  parameter int RET_EXTRA    = 0
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              test_launch,
  input  wire logic [1:0]        background_select,
  input  wire logic              style_check,
  input  wire logic              custom_en,
  input  wire logic              custom_two,
  input  wire logic [DATA_W-1:0] custom_pattern_value,
  input  wire logic [DATA_W-1:0] custom_pattern_second,
  input  wire logic              addr_inv_en,
  input  wire logic              col_inv_en,
  input  wire logic              retention_en,
  input  wire logic              retention_handshake,
  input  wire logic              retention_resume,
  input  wire logic              loop_test_en,
  input  wire logic              bypass_en,
  input  wire logic              bypass_use_reg,
  input  wire logic              bypass_mem_disable,
  input  wire logic              multi_clock_source,
  input  wire logic              bypass_register_clock,
  input  wire logic [ADDR_W-1:0] func_addr,
  input  wire logic [DATA_W-1:0] func_wdata,
  input  wire logic              func_we,
  input  wire logic              func_cs,
  input  wire logic [DATA_W-1:0] mem_rdata,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [DATA_W-1:0] mem_wdata,
  output logic                   mem_we,
  output logic                   mem_cs,
  output logic                   mem_clk_en,
  output logic      [DATA_W-1:0] func_rdata,
  output logic                   scan_clk_sel_test,
  output logic                   test_busy,
  output logic                   test_done,
  output logic                   test_fail,
  output logic                   retention_waiting
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    seq_state_t          state;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          pat;
    logic [31:0]         cnt;
    logic                rd_pend;
    logic [DATA_W-1:0]   exp1;
    logic                cmp_vld;
    logic [DATA_W-1:0]   exp2;
    logic                fail;
    logic                done;
    logic                busy;
    logic                waiting;
    logic [ADDR_W-1:0]   m_addr;
    logic [DATA_W-1:0]   m_wdata;
    logic                m_we;
    logic                m_cs;
    logic                m_clk_en;
    logic [DATA_W-1:0]   rdata_out;
    logic                scan_sel;
    logic [BYP_REGS-1:0] byp;
    logic                bck_prev;
  } core_t;

  core_t s_r;
  core_t s_nxt;

  pattern_if bgi ();

  pattern_gen u_pattern_gen (
    .b (bgi)
  );

  assign bgi.pat_index         = s_r.pat;
  assign bgi.addr              = s_r.addr;
  assign bgi.style_check       = style_check;
  assign bgi.background_select = background_select;
  assign bgi.custom_en         = custom_en;
  assign bgi.custom_two        = custom_two;
  assign bgi.custom_a          = custom_pattern_value;
  assign bgi.custom_b          = custom_pattern_second;
  assign bgi.addr_inv_en       = addr_inv_en;
  assign bgi.col_inv_en        = col_inv_en;

  localparam logic [ADDR_W-1:0] ADDR_LAST = {ADDR_W{1'b1}};
  localparam logic [31:0]       WAIT_LAST = 32'(SLEEP_CYCLES + RET_EXTRA - 1);

  // ****************************************
  // Next state
  // ****************************************
  logic [DATA_W-1:0] fold;
  logic [1:0]        pat_last;

  always_comb
  begin
    s_nxt         = s_r;
    pat_last      = 2'(bgi.pat_count - 3'h1);
    fold          = func_wdata ^ DATA_W'(func_addr) ^ DATA_W'({func_we, func_cs});
    s_nxt.rd_pend = 1'b0;
    s_nxt.m_we    = 1'b0;
    s_nxt.m_cs    = ~CS_ON;
    s_nxt.done    = 1'b0;
    s_nxt.cmp_vld = s_r.rd_pend;
    s_nxt.exp2    = s_r.exp1;
    if (s_r.cmp_vld && (mem_rdata != s_r.exp2))
      s_nxt.fail = 1'b1;
    unique case (s_r.state)
      ST_IDLE:
      begin
        if (test_launch)
        begin
          s_nxt.state = ST_WRITE;
          s_nxt.addr  = '0;
          s_nxt.pat   = '0;
          s_nxt.fail  = 1'b0;
          s_nxt.busy  = 1'b1;
        end
      end
      ST_WRITE:
      begin
        s_nxt.m_addr  = s_r.addr;
        s_nxt.m_wdata = bgi.pattern;
        s_nxt.m_we    = 1'b1;
        s_nxt.m_cs    = CS_ON;
        s_nxt.addr    = ADDR_W'(s_r.addr + 1'b1);
        s_nxt.cnt     = '0;
        if (s_r.addr == ADDR_LAST)
          s_nxt.state = retention_en ? ST_SLEEP : ST_READ;
      end
      ST_SLEEP:
      begin
        if (retention_handshake)
        begin
          s_nxt.waiting = 1'b1;
          if (s_r.waiting && retention_resume)
          begin
            s_nxt.waiting = 1'b0;
            s_nxt.state   = ST_READ;
          end
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 32'h0000_0001;
          if (s_r.cnt >= WAIT_LAST)
            s_nxt.state = ST_READ;
        end
      end
      ST_READ:
      begin
        s_nxt.m_addr  = s_r.addr;
        s_nxt.m_cs    = CS_ON;
        s_nxt.rd_pend = 1'b1;
        s_nxt.exp1    = bgi.pattern;
        s_nxt.addr    = ADDR_W'(s_r.addr + 1'b1);
        if (s_r.addr == ADDR_LAST)
        begin
          s_nxt.state = ST_WRITE;
          s_nxt.pat   = 2'(s_r.pat + 1'b1);
          if (s_r.pat >= pat_last)
          begin
            s_nxt.pat   = '0;
            // Loop mode goes straight back to writing, so no command gap appears.
            s_nxt.state = loop_test_en ? ST_WRITE : ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        // Waits two cycles so the last read is compared before done is shown.
        if (!s_r.cmp_vld && !s_r.rd_pend)
        begin
          s_nxt.state = ST_IDLE;
          s_nxt.done  = 1'b1;
          s_nxt.busy  = 1'b0;
        end
      end
      default:
        s_nxt.state = ST_IDLE;
    endcase

    // ****************************************
    // Bypass path
    // ****************************************
    s_nxt.bck_prev = bypass_register_clock;
    s_nxt.scan_sel = bypass_en & multi_clock_source;
    s_nxt.m_clk_en = 1'b1;
    if (bypass_en && !s_r.busy)
    begin
      s_nxt.m_cs     = bypass_mem_disable ? ~CS_ON : CS_ON;
      s_nxt.m_clk_en = ~bypass_mem_disable;
    end
    if (bypass_register_clock && !s_r.bck_prev)
    begin
      for (int j = 0; j < BYP_REGS; j++)
        s_nxt.byp[j] = ^fold[j*SHARE_N +: SHARE_N];
    end
    s_nxt.rdata_out = mem_rdata;
    if (bypass_en)
    begin
      for (int i = 0; i < DATA_W; i++)
        s_nxt.rdata_out[i] = bypass_use_reg ? s_r.byp[i / SHARE_N] : fold[i];
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign mem_addr          = s_r.m_addr;
  assign mem_wdata         = s_r.m_wdata;
  assign mem_we            = s_r.m_we;
  assign mem_cs            = s_r.m_cs;
  assign mem_clk_en        = s_r.m_clk_en;
  assign func_rdata        = s_r.rdata_out;
  assign scan_clk_sel_test = s_r.scan_sel;
  assign test_busy         = s_r.busy;
  assign test_done         = s_r.done;
  assign test_fail         = s_r.fail;
  assign retention_waiting = s_r.waiting;

endmodule

// File: tb/mem_model.sv
/*
  Behavioural model of the 64x8 memory under test.
  Assumes writes and reads are sampled on sys_clk while chip select and clock enable are high.
*/
`timescale 1ns/100ps
module mem_model
  import selftest_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              clk_en,
  input  wire logic              cs,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              flip,
  output logic      [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem_r [2**ADDR_W];

  // Outside a read the data toggles, so a stale word is never mistaken for a good one.
  always_ff @(posedge clk)
  begin
    if (clk_en && cs && we)
      mem_r[addr] <= wdata;
    rdata <= (clk_en && cs && !we) ? mem_r[addr] ^ {7'b0, flip} : ~rdata;
  end
endmodule

// File: tb/mbist_props.sv
/*
  Port checks of the self-test block.
  Assumes configuration inputs stay steady while a test runs.
*/
`timescale 1ns/100ps
module mbist_props
  import selftest_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic              style_check,
  input wire logic              custom_en,
  input wire logic              addr_inv_en,
  input wire logic              col_inv_en,
  input wire logic              loop_test_en,
  input wire logic              bypass_en,
  input wire logic              bypass_use_reg,
  input wire logic              bypass_mem_disable,
  input wire logic              multi_clock_source,
  input wire logic [ADDR_W-1:0] func_addr,
  input wire logic [DATA_W-1:0] func_wdata,
  input wire logic              func_we,
  input wire logic              func_cs,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_wdata,
  input wire logic              mem_we,
  input wire logic              mem_cs,
  input wire logic              mem_clk_en,
  input wire logic [DATA_W-1:0] func_rdata,
  input wire logic              scan_clk_sel_test,
  input wire logic              test_busy,
  input wire logic              test_done,
  input wire logic              retention_waiting
);
  logic [DATA_W-1:0] fold;
  logic              solid_w;

  assign fold = func_wdata ^ {2'b00, func_addr} ^ {6'b0, func_we, func_cs};
  assign solid_w = test_busy && mem_we && mem_cs && !custom_en && !style_check;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_idle_byp(logic dis);
    !test_busy && !test_done && bypass_en && (bypass_mem_disable == dis);
  endsequence

  AST_SCAN_SEL: assert property ((bypass_en && multi_clock_source) |=> scan_clk_sel_test)
    else $error("scan clock not switched");
  AST_BYP_OFF: assert property (s_idle_byp(1'b1) ##1 s_idle_byp(1'b1) |-> !mem_cs && !mem_clk_en)
    else $error("memory not disabled in bypass");
  AST_BYP_ON: assert property (s_idle_byp(1'b0) ##1 s_idle_byp(1'b0) |-> mem_cs && mem_clk_en)
    else $error("memory not enabled in bypass");
  AST_WIRE: assert property ((bypass_en && !bypass_use_reg) |=> func_rdata == $past(fold))
    else $error("wire bypass value wrong");
  AST_ADDR_INV: assert property (solid_w && addr_inv_en && !col_inv_en |-> mem_wdata == {8{mem_addr[0]}})
    else $error("address inversion wrong");
  AST_COL_INV: assert property (solid_w && !addr_inv_en && col_inv_en |-> mem_wdata == {8{mem_addr[2]}})
    else $error("column inversion wrong");
  AST_BOTH_INV: assert property (solid_w && addr_inv_en && col_inv_en
                                  |-> mem_wdata == {8{mem_addr[0] ^ mem_addr[2]}})
    else $error("combined inversion wrong");
  AST_LOOP: assert property (loop_test_en |-> !test_done)
    else $error("loop test finished");
  AST_WAIT: assert property (retention_waiting |-> !mem_cs && test_busy)
    else $error("access during retention wait");
endmodule

bind mbist_background_and_bypass mbist_props u_mbist_props (.sys_clk, .rst_n, .style_check,
  .custom_en, .addr_inv_en, .col_inv_en, .loop_test_en, .bypass_en, .bypass_use_reg,
  .bypass_mem_disable, .multi_clock_source, .func_addr, .func_wdata, .func_we, .func_cs,
  .mem_addr, .mem_wdata, .mem_we, .mem_cs, .mem_clk_en, .func_rdata, .scan_clk_sel_test,
  .test_busy, .test_done, .retention_waiting);

// File: tb/test_mbist_background_and_bypass.sv
/*
  Self-checking bench of the self-test block with a memory model.
  Assumes sleep shortened to 20 cycles plus 3 extension cycles.
*/
`timescale 1ns/100ps
module test_mbist_background_and_bypass;
  import selftest_pkg::*;
  logic sys_clk, rst_n, test_launch, style_check, custom_en, custom_two, addr_inv_en, col_inv_en;
  logic retention_en, retention_handshake, retention_resume, loop_test_en, bypass_en;
  logic bypass_use_reg, bypass_mem_disable, multi_clock_source, bypass_register_clock;
  logic func_we, func_cs, mem_we, mem_cs, mem_clk_en, scan_clk_sel_test, flip;
  logic test_busy, test_done, test_fail, retention_waiting;
  logic [1:0] background_select;
  logic [5:0] func_addr, mem_addr;
  logic [7:0] custom_pattern_value, custom_pattern_second, func_wdata, func_rdata;
  logic [7:0] mem_rdata, mem_wdata;
  int n_errors = 0;
  int n_checks = 0;

  mbist_background_and_bypass #(.SLEEP_CYCLES(20), .RET_EXTRA(3)) u_mbist_background_and_bypass
    (.sys_clk, .rst_n, .test_launch, .background_select, .style_check, .custom_en, .custom_two,
     .custom_pattern_value, .custom_pattern_second, .addr_inv_en, .col_inv_en, .retention_en,
     .retention_handshake, .retention_resume, .loop_test_en, .bypass_en, .bypass_use_reg,
     .bypass_mem_disable, .multi_clock_source, .bypass_register_clock, .func_addr, .func_wdata,
     .func_we, .func_cs, .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_cs, .mem_clk_en,
     .func_rdata, .scan_clk_sel_test, .test_busy, .test_done, .test_fail, .retention_waiting);
  mem_model u_mem_model (.clk(sys_clk), .clk_en(mem_clk_en), .cs(mem_cs), .we(mem_we),
    .addr(mem_addr), .wdata(mem_wdata), .flip(flip), .rdata(mem_rdata));

  // ****************************************
  // Common tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset();
    rst_n = 0;
    repeat (4) @(posedge sys_clk);
    #1 rst_n = 1;
  endtask

  // Checks every written word against the expected backgrounds and the sleep gap length.
  task automatic run(input int nb, input logic [7:0] r0, r1, r2, r3, input int gmin,
                     input logic efail);
    logic [7:0] raw [4];
    logic [7:0] prev_rd;
    int w, t, h, g, rk;
    raw = '{r0, r1, r2, r3};
    w = 0;
    h = 0;
    g = 0;
    rk = 0;
    prev_rd = 8'h00;
    @(posedge sys_clk) #1 test_launch = 1;
    @(posedge sys_clk) #1 test_launch = 0;
    for (t = 0; t < 4000 && !test_done; t++)
    begin
      if (mem_we && mem_cs)
      begin
        chk(mem_wdata, raw[(w / 64) % nb] ^ {8{(addr_inv_en & mem_addr[0]) ^ (col_inv_en & mem_addr[2])}});
        chk(mem_addr, w % 64);
        w++;
      end
      // Outside bypass the read data path is the memory word one cycle late.
      if (rk > 1)
        chk(func_rdata, prev_rd);
      prev_rd = mem_rdata;
      rk += (rk > 0 || (mem_cs && !mem_we));
      g += (test_busy && !mem_cs);
      h = retention_waiting ? h + 1 : 0;
      retention_resume = retention_waiting && (h == 5);
      if (loop_test_en && w > 64 * nb)
        break;
      @(posedge sys_clk) #1;
    end
    if (t == 4000)
    begin
      n_errors++;
      close_out();
    end
    chk(w, loop_test_en ? 64 * nb + 1 : 64 * nb);
    chk(g >= gmin, 1);
    chk(test_fail, loop_test_en ? 0 : efail);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_select();
    style_check = 1;
    for (int c = 0; c < 4; c++)
    begin
      background_select = c[1:0];
      if (c == 1)
        run(1, 8'h00, 0, 0, 0, 0, 0);
      else if (c == 2)
        run(1, 8'h55, 0, 0, 0, 0, 0);
      else
        run(2, 8'h00, 8'h55, 0, 0, 0, 0);
    end
    style_check = 0;
  endtask

  task automatic t_invert();
    for (int c = 1; c < 4; c++)
    begin
      {col_inv_en, addr_inv_en} = c[1:0];
      run(1, 8'h00, 0, 0, 0, 0, 0);
    end
    {col_inv_en, addr_inv_en} = 0;
  endtask

  task automatic t_custom();
    custom_en = 1;
    custom_pattern_value = 8'h3c;
    custom_pattern_second = 8'h71;
    run(1, 8'h3c, 0, 0, 0, 0, 0);
    style_check = 1;
    run(4, 8'h3c, 8'hc3, 8'h55, 8'haa, 0, 0);
    custom_two = 1;
    run(4, 8'h3c, 8'hc3, 8'h71, 8'h8e, 0, 0);
    {custom_en, custom_two, style_check} = 0;
  endtask

  task automatic t_retain();
    retention_en = 1;
    run(1, 8'h00, 0, 0, 0, 23, 0);
    retention_handshake = 1;
    run(1, 8'h00, 0, 0, 0, 5, 0);
    {retention_en, retention_handshake} = 0;
  endtask

  task automatic t_fault_loop();
    flip = 1;
    run(1, 8'h00, 0, 0, 0, 0, 1);
    flip = 0;
    // Let the done pulse of the previous run pass before loop mode is asked for.
    @(posedge sys_clk) #1 loop_test_en = 1;
    run(1, 8'h00, 0, 0, 0, 0, 0);
    loop_test_en = 0;
    do_reset();
  endtask

  task automatic t_bypass();
    logic [7:0] f;
    {bypass_en, multi_clock_source, func_we, func_cs} = 4'hf;
    func_addr = 6'h2d;
    func_wdata = 8'ha6;
    f = 8'ha6 ^ 8'h2d ^ 8'h03;
    repeat (2) @(posedge sys_clk);
    #1 chk(func_rdata, f);
    chk(scan_clk_sel_test, 1);
    chk({mem_cs, mem_clk_en}, 2'h3);
    bypass_mem_disable = 1;
    repeat (2) @(posedge sys_clk);
    #1 chk({mem_cs, mem_clk_en}, 0);
    bypass_use_reg = 1;
    bypass_register_clock = 1;
    repeat (3) @(posedge sys_clk);
    #1 chk(func_rdata, {{4{^f[7:4]}}, {4{^f[3:0]}}});
    func_wdata = 8'h2e;
    repeat (2) @(posedge sys_clk);
    #1 chk(func_rdata, {{4{^f[7:4]}}, {4{^f[3:0]}}});
    bypass_register_clock = 0;
    @(posedge sys_clk) #1 bypass_register_clock = 1;
    repeat (3) @(posedge sys_clk);
    #1 chk(func_rdata, 8'h00);
    {bypass_en, bypass_use_reg, bypass_mem_disable, bypass_register_clock} = 0;
    @(posedge sys_clk) #1;
  endtask

  initial
  begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    {test_launch, style_check, custom_en, custom_two, addr_inv_en, col_inv_en, flip} = 0;
    {retention_en, retention_handshake, retention_resume, loop_test_en, bypass_en} = 0;
    {bypass_use_reg, bypass_mem_disable, multi_clock_source, bypass_register_clock} = 0;
    {func_we, func_cs, background_select, func_addr} = 0;
    {custom_pattern_value, custom_pattern_second, func_wdata} = 0;
    do_reset();
    t_select();
    t_invert();
    t_custom();
    t_retain();
    t_fault_loop();
    t_bypass();
    close_out();
  end
endmodule
